// file: src/ahbarb_pkg.sv
// Shared constants and carrier types for the fixed-priority bus arbiter
package ahbarb_pkg;

    // Master numbering
    localparam int NUM_MASTERS = 4;
    localparam int MNUM_W = 4;
    localparam logic [3:0] DEFAULT_MASTER = 4'h1;
    localparam logic [3:0] DUMMY_MASTER = 4'h0;

    // Transfer types
    localparam logic [1:0] TRANS_IDLE = 2'h0;
    localparam logic [1:0] TRANS_BUSY = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ = 2'h3;

    // Transfer responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_ERROR = 2'h1;
    localparam logic [1:0] RESP_RETRY = 2'h2;
    localparam logic [1:0] RESP_SPLIT = 2'h3;

    // Burst encodings
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR = 3'h1;
    localparam logic [2:0] BURST_WRAP4 = 3'h2;
    localparam logic [2:0] BURST_INCR4 = 3'h3;
    localparam logic [2:0] BURST_WRAP8 = 3'h4;
    localparam logic [2:0] BURST_INCR8 = 3'h5;
    localparam logic [2:0] BURST_WRAP16 = 3'h6;
    localparam logic [2:0] BURST_INCR16 = 3'h7;

    // Beat counter width and reset value
    localparam int BEAT_W = 5;
    localparam logic [4:0] BEAT_RESET = 5'h00;
    localparam logic [4:0] BEATS_FOUR = 5'h04;
    localparam logic [4:0] BEATS_EIGHT = 5'h08;
    localparam logic [4:0] BEATS_SIXTEEN = 5'h10;
    localparam logic [4:0] BEATS_NONE = 5'h00;
    localparam logic [4:0] BEATS_LAST = 5'h01;

    // Reset values
    localparam logic [3:0] SPLIT_MASK_RESET = 4'h0;
    localparam logic [3:0] GRANT_RESET = 4'h2;

    // Shared bus status seen by the arbiter
    typedef struct packed {
        logic hready;
        logic [1:0] hresp;
        logic [1:0] htrans;
        logic [2:0] hburst;
    } ahbarb_bus_t;

endpackage : ahbarb_pkg

// file: src/ahbarb_prio_enc.sv
// Fixed-priority encoder turning masked requests into a master number
`timescale 1ns/10ps

module ahbarb_prio_enc (
    input wire logic [3:0] req,
    output logic [3:0] winning_requester_num
);

    // Order 3, 0, 2, 1; nobody requesting falls to the default master
    always_comb begin
        if (req[3]) begin
            winning_requester_num = 4'h3;
        end else if (req[0]) begin
            winning_requester_num = ahbarb_pkg::DUMMY_MASTER;
        end else if (req[2]) begin
            winning_requester_num = 4'h2;
        end else begin
            winning_requester_num = ahbarb_pkg::DEFAULT_MASTER;
        end
    end

endmodule : ahbarb_prio_enc

// file: src/ahbarb_arbiter.sv
// Fixed-priority four-master bus arbiter with lock and split handling
`timescale 1ns/10ps

// What this block does
// - Sample all bus requests each cycle, encode the top requester as 4 bits.
// - When bus is free, decode winner into one-hot grants taking effect on ready.
// - Hold current grant through fixed-length bursts and locked transfers.
// - Pipeline granted, address-owner and data-owner numbers, advancing only on ready.
// - Priority order is 3, 0, 2, 1; master 1 is default when idle.
// - Master 0 is a dummy, granted when it requests or on a split locked master.
// - Priority encoder works on requests with split-blocked masters removed.
// - Lock counts if asserted when granted; master stays sole grantee until released.
// - Master lock output selects the lock input of the currently granted master.
// - While locked, the next grant equals the current grant.
// - Keep one split mask bit per bus master.
// - Split response sets the master's bit; split-release line clears it.
// - Split-blocked masters' requests are masked before arbitration.
// - Split on a locked master forces grant and owner to dummy until release.
// - Split/retry ending a locked phase reverts grant: dummy after split, locked master after retry.
// - Split-release input is four bits, one per master number.
module ahbarb_arbiter (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire ahbarb_pkg::ahbarb_bus_t bus,
    input wire logic [3:0] hbusreq,
    input wire logic [3:0] hlock,
    input wire logic [3:0] hsplit,
    output logic [3:0] hgrant,
    output logic [3:0] hmaster,
    output logic hmastlock
);

    // One-hot decode of a master number
    // Numbers above three select no line, so they give an all-zero vector
    function automatic logic [3:0] onehot(input logic [3:0] num);
        logic [3:0] vec;
        vec = 4'h0;
        vec[num[1:0]] = (num[3:2] == 2'h0);
        return vec;
    endfunction : onehot

    // Beats in a fixed-length burst, zero for single or undefined length
    // INCR and SINGLE give zero and are never held, so long bursts cannot starve others
    function automatic logic [4:0] burst_beats(input logic [2:0] burst);
        logic [4:0] n;
        n = ahbarb_pkg::BEATS_NONE;
        if (burst == ahbarb_pkg::BURST_WRAP4 || burst == ahbarb_pkg::BURST_INCR4) begin
            n = ahbarb_pkg::BEATS_FOUR;
        end else if (burst == ahbarb_pkg::BURST_WRAP8 || burst == ahbarb_pkg::BURST_INCR8) begin
            n = ahbarb_pkg::BEATS_EIGHT;
        end else if (burst == ahbarb_pkg::BURST_WRAP16 || burst == ahbarb_pkg::BURST_INCR16) begin
            n = ahbarb_pkg::BEATS_SIXTEEN;
        end
        return n;
    endfunction : burst_beats

    logic [3:0] granted_master_num_q;
    logic [3:0] granted_master_num_d;
    logic [3:0] address_owner_num_q;
    logic [3:0] data_owner_num_q;
    logic [3:0] split_block_mask_q;
    logic [3:0] split_block_mask_d;
    logic [3:0] hgrant_q;
    logic hmastlock_q;
    logic data_lock_q;
    logic locked_split_q;
    logic [3:0] locked_split_num_q;
    logic retry_pend_q;
    logic [4:0] beats_left_q;
    logic [3:0] masked_req;
    logic [3:0] winning_requester_num;
    logic split_evt;
    logic retry_evt;
    logic burst_start;
    logic burst_hold;
    logic lock_hold;
    logic nonseq_taken;
    logic seq_taken;

    // Blocked masters never reach the encoder
    assign masked_req = hbusreq & ~split_block_mask_q;

    // Top requester among unblocked masters
    ahbarb_prio_enc u_prio_enc (
        .req(masked_req),
        .winning_requester_num(winning_requester_num)
    );

    // First cycle of a two-cycle split or retry answer
    assign split_evt = !bus.hready && bus.hresp == ahbarb_pkg::RESP_SPLIT;
    assign retry_evt = !bus.hready && bus.hresp == ahbarb_pkg::RESP_RETRY;

    // Accepted address phases for burst tracking
    assign nonseq_taken = bus.hready && bus.htrans == ahbarb_pkg::TRANS_NONSEQ;
    assign seq_taken = bus.hready && bus.htrans == ahbarb_pkg::TRANS_SEQ;

    // A fixed burst starting now must already hold the grant at its NONSEQ edge,
    // or the next master would be granted while beats two onwards are still due
    assign burst_start = nonseq_taken && burst_beats(bus.hburst) > ahbarb_pkg::BEATS_LAST;

    // Hold while more than the last beat remains, and while the grantee locks
    assign burst_hold = burst_start || beats_left_q > ahbarb_pkg::BEATS_LAST;
    assign lock_hold = hlock[granted_master_num_q[1:0]] || hmastlock_q;

    // Next grant selection, forced cases first
    // Locked split beats retry, which beats the burst and lock holds
    always_comb begin
        if (locked_split_q) begin
            granted_master_num_d = ahbarb_pkg::DUMMY_MASTER;
        end else if (retry_pend_q) begin
            granted_master_num_d = data_owner_num_q;
        end else if (burst_hold || lock_hold) begin
            granted_master_num_d = granted_master_num_q;
        end else begin
            granted_master_num_d = winning_requester_num;
        end
    end

    // Grant number and its one-hot copy move together on ready
    // Only a ready edge moves them, so the grant never flickers in wait states
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            granted_master_num_q <= ahbarb_pkg::DEFAULT_MASTER;
            hgrant_q <= ahbarb_pkg::GRANT_RESET;
        end else if (clk_en && bus.hready) begin
            granted_master_num_q <= granted_master_num_d;
            hgrant_q <= onehot(granted_master_num_d);
        end
    end

    // Address and data owner stages, with lock carried alongside
    // The data stage lock tells split and retry whether the failing phase was locked
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            address_owner_num_q <= ahbarb_pkg::DEFAULT_MASTER;
            data_owner_num_q <= ahbarb_pkg::DEFAULT_MASTER;
            hmastlock_q <= 1'b0;
            data_lock_q <= 1'b0;
        end else if (clk_en && bus.hready) begin
            if (locked_split_q) begin
                address_owner_num_q <= ahbarb_pkg::DUMMY_MASTER;
                hmastlock_q <= 1'b0;
            end else begin
                address_owner_num_q <= granted_master_num_q;
                hmastlock_q <= hlock[granted_master_num_q[1:0]];
            end
            data_owner_num_q <= address_owner_num_q;
            data_lock_q <= hmastlock_q;
        end
    end

    // Split mask: a split sets, a release clears, set wins
    // Clearing first and setting after lets a split in the release cycle win
    always_comb begin
        split_block_mask_d = split_block_mask_q & ~hsplit;
        if (split_evt) begin
            split_block_mask_d = split_block_mask_d | onehot(data_owner_num_q);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            split_block_mask_q <= ahbarb_pkg::SPLIT_MASK_RESET;
        end else if (clk_en) begin
            split_block_mask_q <= split_block_mask_d;
        end
    end

    // Locked-split tracker keeps the dummy on the bus until the master is unsplit
    // Release looks at the registered mask, so the dummy stays one cycle past hsplit
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            locked_split_q <= 1'b0;
            locked_split_num_q <= ahbarb_pkg::DUMMY_MASTER;
        end else if (clk_en) begin
            if (split_evt && data_lock_q) begin
                locked_split_q <= 1'b1;
                locked_split_num_q <= data_owner_num_q;
            end else if (locked_split_q && !split_block_mask_q[locked_split_num_q[1:0]]) begin
                locked_split_q <= 1'b0;
            end
        end
    end

    // Retry on a locked data phase returns the grant to the locked master
    // Cleared on the next ready edge, which is the second response cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            retry_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (retry_evt && data_lock_q) begin
                retry_pend_q <= 1'b1;
            end else if (bus.hready) begin
                retry_pend_q <= 1'b0;
            end
        end
    end

    // Fixed-length burst beat counter; aborted by idle or a non-okay answer
    // Only NONSEQ reloads it; a BUSY beat leaves the count alone
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            beats_left_q <= ahbarb_pkg::BEAT_RESET;
        end else if (clk_en) begin
            if (split_evt || retry_evt || (!bus.hready && bus.hresp == ahbarb_pkg::RESP_ERROR)) begin
                beats_left_q <= ahbarb_pkg::BEAT_RESET;
            end else if (nonseq_taken) begin
                beats_left_q <= burst_beats(bus.hburst);
            end else if (seq_taken && beats_left_q != ahbarb_pkg::BEATS_NONE) begin
                beats_left_q <= beats_left_q - ahbarb_pkg::BEATS_LAST;
            end else if (bus.hready && bus.htrans == ahbarb_pkg::TRANS_IDLE) begin
                beats_left_q <= ahbarb_pkg::BEAT_RESET;
            end
        end
    end

    // Outputs straight from flops
    // Registered outputs keep slaves free of arbitration glitches
    assign hgrant = hgrant_q;
    assign hmaster = address_owner_num_q;
    assign hmastlock = hmastlock_q;

endmodule : ahbarb_arbiter

// file: verification/ahbarb_chk.sv
// Port-level checks for the bus arbiter
`timescale 1ns/10ps
module ahbarb_chk (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire ahbarb_pkg::ahbarb_bus_t bus,
    input wire logic [3:0] hbusreq,
    input wire logic [3:0] hlock,
    input wire logic [3:0] hsplit,
    input wire logic [3:0] hgrant,
    input wire logic [3:0] hmaster,
    input wire logic hmastlock
);
    logic [3:0] gnum;
    logic adv;
    logic lsel;
    logic dlock_q;
    logic lsplit;
    // Granted master number, its lock line and pipeline advance
    assign gnum = {2'h0, hgrant[3] | hgrant[2], hgrant[3] | hgrant[1]};
    assign lsel = hlock[gnum[1:0]];
    assign adv = bus.hready & clk_en;
    // Lock of the phase now in data, and a split answer ending such a phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dlock_q <= 1'b0;
        end else if (adv) begin
            dlock_q <= hmastlock;
        end
    end
    assign lsplit = dlock_q && bus.hresp == ahbarb_pkg::RESP_SPLIT;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Grant, owner and lock pipeline relations
    onehot_grant_a: assert property ($onehot(hgrant))
        else $error("grant not one-hot");
    grant_wait_a: assert property (!adv |=> $stable(hgrant))
        else $error("grant moved in a wait");
    owner_wait_a: assert property (!adv |=> $stable(hmaster) && $stable(hmastlock))
        else $error("owner moved in a wait");
    owner_follow_a: assert property (adv && !lsplit |=> hmaster == $past(gnum))
        else $error("owner is not the old grant");
    split_dummy_a: assert property (adv && lsplit |=> hgrant == 4'h1 && hmaster == 4'h0)
        else $error("locked split did not park the dummy");
    reset_val_a: assert property (
        $rose(arst_n) |-> hgrant == 4'h2 && hmaster == 4'h1 && !hmastlock)
        else $error("bad state after reset");
    default_idle_a: assert property (
        adv && hbusreq == 4'h0 && hlock == 4'h0 && !hmastlock && bus.htrans == 2'h0
        && hgrant != 4'h1 |=> hgrant == 4'h2) else $error("idle bus not on default");
    lock_hold_a: assert property (
        adv && hmastlock && (hgrant & hlock) != 4'h0 && bus.hresp == 2'h0
        |=> $stable(hgrant)) else $error("locked grant moved");
    lock_select_a: assert property (
        adv && !lsplit && gnum != 4'h0 && $stable(hlock) |=> hmastlock == $past(lsel))
        else $error("lock output not from grantee");
endmodule : ahbarb_chk

// file: verification/ahbarb_slave.sv
// Behavioural slave answering each accepted transfer
`timescale 1ns/10ps
module ahbarb_slave (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [1:0] htrans,
    input wire logic [3:0] wait_cnt,
    input wire logic [1:0] resp_sel,
    output logic hready,
    output logic [1:0] hresp
);
    logic act_q;
    logic [5:0] cfg_q;
    logic [3:0] left_q;
    // Capture an accepted active transfer and the planned answer
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            act_q <= 1'b0;
            cfg_q <= 6'h00;
        end else begin
            act_q <= hready & htrans[1];
            cfg_q <= {wait_cnt, resp_sel};
        end
    end
    // Answer mid-cycle; a non-okay answer is two cycles, the first not ready
    always_ff @(negedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hready <= 1'b1;
            hresp <= 2'h0;
            left_q <= 4'h0;
        end else if (act_q) begin
            hready <= (cfg_q == 6'h00);
            hresp <= cfg_q[1:0];
            left_q <= (cfg_q[1:0] != 2'h0) ? 4'h1 : cfg_q[5:2];
        end else if (left_q > 4'h1) begin
            left_q <= left_q - 4'h1;
        end else begin
            hready <= 1'b1;
            left_q <= 4'h0;
            hresp <= (left_q == 4'h0) ? 2'h0 : hresp;
        end
    end
endmodule : ahbarb_slave

// file: verification/tb.sv
// Self-checking bench for the fixed-priority arbiter
`timescale 1ns/10ps
module tb;
    logic sys_clk, arst_n, clk_en, s_rdy, hmastlock;
    logic [3:0] hbusreq, hlock, hsplit, wait_cnt, hgrant, hmaster;
    logic [1:0] htrans, resp_sel, s_resp;
    logic [2:0] hburst;
    ahbarb_pkg::ahbarb_bus_t bus;
    int fail_count;
    int total_checks;
    assign bus = {s_rdy, s_resp, htrans, hburst};
    ahbarb_arbiter DUT (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .bus(bus),
        .hbusreq(hbusreq), .hlock(hlock), .hsplit(hsplit), .hgrant(hgrant),
        .hmaster(hmaster), .hmastlock(hmastlock));
    ahbarb_slave SLV (.sys_clk(sys_clk), .arst_n(arst_n), .htrans(htrans),
        .wait_cnt(wait_cnt), .resp_sel(resp_sel), .hready(s_rdy), .hresp(s_resp));
    // Shared helpers
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic own(input logic [3:0] req, input logic [3:0] num);
        hbusreq = req;
        for (int i = 0; i < 20 && hmaster !== num; i++) step(1);
        chk(hmaster, num);
    endtask : own
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    // Request table, then a frozen clock enable
    task automatic t_prio;
        logic [3:0] req [6] = '{4'hF, 4'h7, 4'h6, 4'h2, 4'h0, 4'h5};
        logic [3:0] gnt [6] = '{4'h8, 4'h1, 4'h4, 4'h2, 4'h2, 4'h1};
        logic [3:0] num [6] = '{4'h3, 4'h0, 4'h2, 4'h1, 4'h1, 4'h0};
        for (int i = 0; i < 6; i++) begin
            hbusreq = req[i];
            step(2);
            chk(hgrant, gnt[i]);
            chk(hmaster, num[i]);
        end
        clk_en = 1'b0;
        hbusreq = 4'h8;
        step(2);
        chk(hgrant, 4'h1);
        clk_en = 1'b1;
        $display("priority test done");
    endtask : t_prio
    // Fixed burst keeps master 2 despite a higher request
    task automatic t_burst;
        own(4'h4, 4'h2);
        htrans = ahbarb_pkg::TRANS_NONSEQ;
        hburst = ahbarb_pkg::BURST_INCR4;
        hbusreq = 4'hC;
        step(1);
        htrans = ahbarb_pkg::TRANS_SEQ;
        chk(hgrant, 4'h4);
        step(1);
        chk(hgrant, 4'h4);
        step(2);
        htrans = ahbarb_pkg::TRANS_IDLE;
        hburst = ahbarb_pkg::BURST_SINGLE;
        step(2);
        chk(hgrant, 4'h8);
        $display("burst test done");
    endtask : t_burst
    // Lock held through slow transfers, released on lock drop
    task automatic t_lock;
        hlock = 4'h4;
        own(4'h4, 4'h2);
        hbusreq = 4'hC;
        wait_cnt = 4'h3;
        htrans = ahbarb_pkg::TRANS_NONSEQ;
        step(6);
        chk(hgrant, 4'h4);
        chk({3'h0, hmastlock}, 4'h1);
        hlock = 4'h0;
        step(10);
        chk(hgrant, 4'h8);
        htrans = ahbarb_pkg::TRANS_IDLE;
        wait_cnt = 4'h0;
        hbusreq = 4'h0;
        step(4);
        $display("lock test done");
    endtask : t_lock
    // Split on master 2, plain or locked, then release
    task automatic t_split(input logic lk);
        hlock = {1'b0, lk, 2'h0};
        own(4'h4, 4'h2);
        htrans = ahbarb_pkg::TRANS_NONSEQ;
        resp_sel = ahbarb_pkg::RESP_SPLIT;
        step(1);
        htrans = ahbarb_pkg::TRANS_IDLE;
        resp_sel = ahbarb_pkg::RESP_OKAY;
        step(2);
        chk(hgrant, lk ? 4'h1 : 4'h2);
        step(4);
        chk(hgrant, lk ? 4'h1 : 4'h2);
        chk(hmaster, lk ? 4'h0 : 4'h1);
        hsplit = 4'h4;
        step(1);
        hsplit = 4'h0;
        step(4);
        chk(hgrant, 4'h4);
        hlock = 4'h0;
        hbusreq = 4'h0;
        step(4);
        $display("split test done");
    endtask : t_split
    // Locked master drops its lock on a last transfer that is retried
    task automatic t_retry;
        hlock = 4'h4;
        own(4'h4, 4'h2);
        htrans = ahbarb_pkg::TRANS_NONSEQ;
        resp_sel = ahbarb_pkg::RESP_RETRY;
        hlock = 4'h0;
        hbusreq = 4'hC;
        step(1);
        htrans = ahbarb_pkg::TRANS_IDLE;
        resp_sel = ahbarb_pkg::RESP_OKAY;
        step(2);
        chk(hgrant, 4'h4);
        step(2);
        chk(hgrant, 4'h8);
        hbusreq = 4'h0;
        step(4);
        $display("retry test done");
    endtask : t_retry
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Watchdog
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
    // Main sequence
    initial begin
        {arst_n, hbusreq, hlock, hsplit, htrans, hburst, resp_sel, wait_cnt} = '0;
        clk_en = 1'b1;
        fail_count = 0;
        total_checks = 0;
        step(8);
        chk(hgrant, 4'h2);
        chk(hmaster, 4'h1);
        arst_n = 1'b1;
        step(2);
        t_prio();
        t_burst();
        t_lock();
        t_split(1'b0);
        t_split(1'b1);
        t_retry();
        close_out();
    end
endmodule : tb
bind ahbarb_arbiter ahbarb_chk CHK (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .bus(bus), .hbusreq(hbusreq), .hlock(hlock), .hsplit(hsplit), .hgrant(hgrant),
    .hmaster(hmaster), .hmastlock(hmastlock));
